// *** src/rjb_pkg.sv ***
`default_nettype none
package rjb_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INSTR  = 8'h04;
  localparam logic [7:0] OFS_PC     = 8'h08;
  localparam logic [7:0] OFS_SRC    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_LINK   = 8'h14;
  localparam logic [7:0] OFS_LIDX   = 8'h18;
  localparam logic [7:0] OFS_TARGET = 8'h1c;
  // control field positions
  localparam int CTRL_COMPACT = 0;
  localparam int CTRL_GO      = 1;
  localparam int CTRL_MODE    = 2;
  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_RESV = 1;
  localparam int ST_AERR = 2;
  localparam int ST_DONE = 3;
  localparam int ST_HAZ  = 4;
  localparam int ST_MODE = 5;
  // instruction encodings
  localparam logic [5:0] OP_EXCH  = 6'h1d;
  localparam logic [5:0] OP_FUNC  = 6'h00;
  localparam logic [5:0] FN_JR    = 6'h08;
  localparam logic [5:0] FN_JALR  = 6'h09;
  localparam logic [4:0] LINK_RA  = 5'h1f;
  localparam int         HB_BIT   = 10;
  // address steps
  localparam logic [31:0] LINK_OFS = 32'h0000_0008;
  localparam logic [31:0] SLOT_OFS = 32'h0000_0004;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // sequencer states, gray along the path
  typedef enum logic [1:0] {
    SQ_IDLE  = 2'h0,
    SQ_SLOT  = 2'h1,
    SQ_TGT   = 2'h3,
    SQ_FETCH = 2'h2
  } rjb_state_t;
  // whole state of the block
  typedef struct packed {
    rjb_state_t  state;
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] src;
    logic [31:0] target;
    logic [31:0] link;
    logic [4:0]  link_idx;
    logic        link_we;
    logic        compact;
    logic        mode;
    logic        next_mode;
    logic        barrier;
    logic        pre_haz;
    logic        slot_haz;
    logic        f_resv;
    logic        f_aerr;
    logic        f_done;
    logic        slot_valid;
    logic        fetch_valid;
    logic        haz_clear;
    logic        ph_wr;
    logic        ph_rd;
    logic [7:0]  ph_addr;
    logic [31:0] hrdata;
  } rjb_regs_t;
endpackage
`default_nettype wire

// *** src/rjb_unit.sv ***
// How it works
// RULE1 - software never sets source equal link register
// RULE2 - plain core: nonzero low bits fault at fetch
// RULE3 - compact core: bit0 zero, bit1 one faults
// RULE4 - link register gets jump address plus eight
// RULE5 - plain: full value; compact: bit0 to mode
// RULE6 - delay slot always runs before target
// RULE7 - software keeps branches out of delay slot
// RULE8 - barrier clears only hazards before the jump
// RULE9 - software clears stream hazards before using code
// RULE10 - exchange target: index shifted, slot-address top
// RULE11 - exchange link bit0 equals current mode
// RULE12 - exchange jump toggles the instruction mode
// RULE13 - exchange without compact code is reserved
// RULE14 - software gives exchange word-aligned targets
// RULE15 - region taken from delay slot address
// RULE16 - hint zero means default handling
// RULE17 - instruction bit ten selects barrier form
// RULE18 - barrier resolves hazards before target fetch
// RULE19 - barrier jumps legal in every mode
// RULE20 - software returns through register thirty-one
// RULE21 - decode by opcode, function and zero fields
// RULE22 - misaligned target still loads pc first
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rjb_unit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        hazard_set,
  output logic             hazard_pending,
  output logic             hazard_clear,
  output logic             slot_valid,
  output logic             fetch_valid,
  output logic [31:0]      fetch_pc,
  output logic             instr_mode,
  output logic             link_valid,
  output logic [4:0]       link_idx,
  output logic [31:0]      link_value
);
  rjb_pkg::rjb_regs_t r;       // current state
  rjb_pkg::rjb_regs_t next_r;  // next state
  logic        start;          // decode taken this cycle
  logic        is_exch;        // exchange call decoded
  logic        is_jr;          // register jump decoded
  logic        is_jalr;        // register call decoded
  logic        known;          // any of the three
  logic        acc;            // address phase taken
  logic        misalign;       // fetch alignment fault
  logic [31:0] slot_pc;        // delay slot address
  logic [3:0]  slot_hi;        // region bits of slot
  logic [31:0] rd_mux;         // register read value

  // decode the held instruction word
  assign is_exch = r.instr[31:26] == rjb_pkg::OP_EXCH;  // RULE21
  assign is_jr   = r.instr[31:26] == rjb_pkg::OP_FUNC
                && r.instr[5:0] == rjb_pkg::FN_JR
                && r.instr[20:11] == 10'h000;  // RULE21
  assign is_jalr = r.instr[31:26] == rjb_pkg::OP_FUNC
                && r.instr[5:0] == rjb_pkg::FN_JALR
                && r.instr[20:16] == 5'h00;  // RULE21
  assign known   = is_exch | is_jr | is_jalr;
  assign slot_pc = r.pc + rjb_pkg::SLOT_OFS;
  assign slot_hi = slot_pc[31:28];

  // fetch fault check on the loaded pc
  always_comb
  begin
    if (r.compact)
      misalign = !r.mode && r.pc[1];  // RULE3
    else
      misalign = r.pc[1:0] != 2'h0;  // RULE2
  end

  // bus address phase accepted
  assign acc = hsel && htrans[1] && hready;

  // register read mux
  always_comb
  begin
    rd_mux = rjb_pkg::RST_WORD;
    case (r.ph_addr)
      rjb_pkg::OFS_CTRL:
      begin
        rd_mux[rjb_pkg::CTRL_COMPACT] = r.compact;
        rd_mux[rjb_pkg::CTRL_MODE]    = r.mode;
      end
      rjb_pkg::OFS_INSTR:  rd_mux = r.instr;
      rjb_pkg::OFS_PC:     rd_mux = r.pc;
      rjb_pkg::OFS_SRC:    rd_mux = r.src;
      rjb_pkg::OFS_STATUS:
      begin
        rd_mux[rjb_pkg::ST_BUSY] = r.state != rjb_pkg::SQ_IDLE;
        rd_mux[rjb_pkg::ST_RESV] = r.f_resv;
        rd_mux[rjb_pkg::ST_AERR] = r.f_aerr;
        rd_mux[rjb_pkg::ST_DONE] = r.f_done;
        rd_mux[rjb_pkg::ST_HAZ]  = r.pre_haz;
        rd_mux[rjb_pkg::ST_MODE] = r.mode;
      end
      rjb_pkg::OFS_LINK:   rd_mux = r.link;
      rjb_pkg::OFS_LIDX:   rd_mux[4:0] = r.link_idx;
      rjb_pkg::OFS_TARGET: rd_mux = r.target;
      // unmapped offsets read zero
      default:             rd_mux = rjb_pkg::RST_WORD;
    endcase
  end

  // next state: bus first, sequencer after so its sets win
  always_comb
  begin
    next_r             = r;
    start              = 1'b0;
    next_r.slot_valid  = 1'b0;
    next_r.fetch_valid = 1'b0;
    next_r.haz_clear   = 1'b0;
    next_r.link_we     = 1'b0;
    // hazards raised outside a barrier are remembered
    next_r.pre_haz     = r.pre_haz | hazard_set;
    // read data phase: one wait cycle, then data
    if (r.ph_rd)
    begin
      next_r.hrdata = rd_mux;
      next_r.ph_rd  = 1'b0;
    end
    // write data phase
    if (r.ph_wr)
    begin
      next_r.ph_wr = 1'b0;
      case (r.ph_addr)
        rjb_pkg::OFS_CTRL:
        begin
          if (r.state == rjb_pkg::SQ_IDLE)
          begin
            next_r.compact = hwdata[rjb_pkg::CTRL_COMPACT];
            next_r.mode    = hwdata[rjb_pkg::CTRL_MODE];
            start          = hwdata[rjb_pkg::CTRL_GO];
          end
        end
        rjb_pkg::OFS_INSTR:
        begin
          if (r.state == rjb_pkg::SQ_IDLE)
            next_r.instr = hwdata;
        end
        rjb_pkg::OFS_PC:
        begin
          if (r.state == rjb_pkg::SQ_IDLE)
            next_r.pc = hwdata;
        end
        rjb_pkg::OFS_SRC:
        begin
          if (r.state == rjb_pkg::SQ_IDLE)
            next_r.src = hwdata;
        end
        rjb_pkg::OFS_STATUS:
        begin
          // write one to clear sticky flags
          if (hwdata[rjb_pkg::ST_RESV])
            next_r.f_resv = 1'b0;
          if (hwdata[rjb_pkg::ST_AERR])
            next_r.f_aerr = 1'b0;
          if (hwdata[rjb_pkg::ST_DONE])
            next_r.f_done = 1'b0;
        end
        // other offsets ignore writes
        default: next_r.ph_wr = 1'b0;
      endcase
    end
    // new address phase
    if (acc)
    begin
      next_r.ph_addr = haddr[7:0];
      next_r.ph_wr   = hwrite;
      next_r.ph_rd   = !hwrite;
    end
    // jump sequencer
    case (r.state)
      rjb_pkg::SQ_IDLE:
      begin
        if (start)
        begin
          if (!known || (is_exch && !r.compact))
            next_r.f_resv = 1'b1;  // RULE13
          else
          begin
            // no privilege gate on the barrier forms
            next_r.barrier = !is_exch && r.instr[rjb_pkg::HB_BIT];  // RULE17 RULE19
            // hint bits below the barrier bit are default handling
            next_r.slot_haz = 1'b0;  // RULE16
            next_r.link     = r.pc + rjb_pkg::LINK_OFS;  // RULE4
            next_r.link_we  = is_exch || is_jalr;
            next_r.link_idx = is_exch ? rjb_pkg::LINK_RA : r.instr[15:11];
            if (is_exch)
            begin
              next_r.link[0]   = r.mode;  // RULE11
              next_r.target    = {slot_hi, r.instr[25:0], 2'b00};  // RULE10 RULE15
              next_r.next_mode = !r.mode;  // RULE12
            end
            else if (r.compact)
            begin
              next_r.target    = {r.src[31:1], 1'b0};  // RULE5
              next_r.next_mode = r.src[0];  // RULE5
            end
            else
            begin
              next_r.target    = r.src;  // RULE5
              next_r.next_mode = r.mode;
            end
            next_r.state = rjb_pkg::SQ_SLOT;
          end
        end
      end
      rjb_pkg::SQ_SLOT:
      begin
        // delay slot instruction issues here
        next_r.slot_valid = 1'b1;  // RULE6
        next_r.pc         = slot_pc;  // RULE6
        next_r.slot_haz   = hazard_set;  // RULE8
        next_r.state      = rjb_pkg::SQ_TGT;
      end
      rjb_pkg::SQ_TGT:
      begin
        next_r.pc   = r.target;  // RULE22
        next_r.mode = r.next_mode;  // RULE12
        if (r.barrier)
        begin
          // drop older hazards, keep those of the slot
          next_r.haz_clear = 1'b1;  // RULE18
          next_r.pre_haz   = r.slot_haz | hazard_set;  // RULE8
        end
        next_r.state = rjb_pkg::SQ_FETCH;
      end
      rjb_pkg::SQ_FETCH:
      begin
        // fault is raised at the fetch, not at the jump
        if (misalign)
          next_r.f_aerr = 1'b1;  // RULE2 RULE3 RULE22
        else
          next_r.fetch_valid = 1'b1;
        next_r.f_done = 1'b1;
        next_r.state  = rjb_pkg::SQ_IDLE;
      end
      default: next_r.state = rjb_pkg::SQ_IDLE;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  // outputs
  assign hreadyout      = !r.ph_rd;
  assign hrdata         = r.hrdata;
  assign hresp          = 1'b0;
  assign hazard_pending = r.pre_haz;
  assign hazard_clear   = r.haz_clear;
  assign slot_valid     = r.slot_valid;
  assign fetch_valid    = r.fetch_valid;
  assign fetch_pc       = r.pc;
  assign instr_mode     = r.mode;
  assign link_valid     = r.link_we;
  assign link_idx       = r.link_idx;
  assign link_value     = r.link;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_LINK_PLUS8: assert property ( // RULE4
    (r.link_we && !is_exch) |-> r.link == r.pc + rjb_pkg::LINK_OFS)
    else $error("link value is not jump address plus eight");
  AST_EXCH_LINK_MODE: assert property ( // RULE11
    (start && is_exch && r.compact) |=> r.link[0] == $past(r.mode))
    else $error("exchange link bit0 differs from mode");
  AST_SLOT_FIRST: assert property ( // RULE6
    (r.state == rjb_pkg::SQ_SLOT) |=> r.slot_valid && r.pc == $past(slot_pc)
      ##1 r.pc == $past(r.target))
    else $error("delay slot did not run before target");
  AST_PLAIN_TARGET: assert property ( // RULE5
    (start && is_jr && !r.compact) |=> r.target == $past(r.src))
    else $error("plain target is not the full register");
  AST_COMPACT_TARGET: assert property ( // RULE5
    (start && is_jr && r.compact) |=> !r.target[0] && r.next_mode == $past(r.src[0]))
    else $error("compact target bit0 or mode wrong");
  AST_EXCH_TARGET: assert property ( // RULE10
    (start && is_exch && r.compact) |=> r.target[31:28] == $past(slot_hi)
      && r.target[27:0] == {$past(r.instr[25:0]), 2'b00})
    else $error("exchange target badly formed");
  AST_MODE_TOGGLE: assert property ( // RULE12
    (r.state == rjb_pkg::SQ_TGT && is_exch) |=> r.mode != $past(r.mode))
    else $error("exchange did not toggle mode");
  AST_RESERVED: assert property ( // RULE13
    (start && is_exch && !r.compact) |=> r.f_resv && r.state == rjb_pkg::SQ_IDLE && !r.link_we)
    else $error("exchange without compact code not refused");
  AST_PLAIN_FAULT: assert property ( // RULE2
    (r.state == rjb_pkg::SQ_FETCH && !r.compact && r.pc[1:0] != 2'h0)
      |=> r.f_aerr && !r.fetch_valid)
    else $error("plain misaligned fetch not faulted");
  AST_COMPACT_FAULT: assert property ( // RULE3
    (r.state == rjb_pkg::SQ_FETCH && r.compact)
      |=> r.f_aerr == ($past(r.f_aerr) || ($past(r.pc[1]) && !$past(r.mode))))
    else $error("compact fetch fault wrong");
  AST_FAULT_AFTER_PC: assert property ( // RULE22
    (r.state == rjb_pkg::SQ_TGT) |=> r.pc == $past(r.target) && r.state == rjb_pkg::SQ_FETCH ##1 r.f_done)
    else $error("pc not loaded before fault report");
  AST_BARRIER_CLEAR: assert property ( // RULE18
    (r.state == rjb_pkg::SQ_TGT && r.barrier && !r.slot_haz && !hazard_set)
      |=> r.haz_clear && !r.pre_haz ##1 r.fetch_valid || r.f_aerr)
    else $error("barrier did not clear before fetch");
  AST_SLOT_HAZ_KEPT: assert property ( // RULE8
    (r.state == rjb_pkg::SQ_TGT && r.slot_haz) |=> r.pre_haz)
    else $error("delay slot hazard was cleared");
  AST_HB_SELECT: assert property ( // RULE17
    (start && is_jr) |=> r.barrier == $past(r.instr[rjb_pkg::HB_BIT]))
    else $error("barrier bit not honoured");
  AST_EXCH_LINK_RA: assert property ( // RULE11
    (start && is_exch && r.compact) |=> r.link_we && r.link_idx == rjb_pkg::LINK_RA)
    else $error("exchange link not written to register 31");
  AST_FETCH_ALIGNED: assert property ( // RULE2 RULE3
    r.fetch_valid |-> !misalign)
    else $error("target fetched from a misaligned address");
  AST_CLEAR_ONLY_BARRIER: assert property ( // RULE18
    r.haz_clear |-> $past(r.state) == rjb_pkg::SQ_TGT && $past(r.barrier))
    else $error("hazard clear without a barrier jump");

  COV_EXCH: cover property (r.state == rjb_pkg::SQ_TGT && is_exch);
  COV_BARRIER: cover property (r.haz_clear);
  COV_FAULT: cover property (r.f_aerr);
  COV_RESV: cover property (r.f_resv);
  // a register call writing its link
  COV_CALL_LINK: cover property (r.link_we && !is_exch);
endmodule
`default_nettype wire

// *** dv/register_jump_hazard_barrier_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module register_jump_hazard_barrier_bench;
  logic        clk;            // core clock, 8 ns
  logic        rst_n;          // synchronous reset
  logic        hsel;           // bus select
  logic [31:0] haddr;          // bus address
  logic [1:0]  htrans;         // bus transfer kind
  logic        hwrite;         // bus direction
  logic [2:0]  hsize;          // bus size, words only
  logic [31:0] hwdata;         // bus write data
  wire         hready;         // single slave: its own ready
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        hazard_set;     // hazard raised by core logic
  logic        hazard_pending;
  logic        hazard_clear;
  logic        slot_valid;
  logic        fetch_valid;
  logic [31:0] fetch_pc;
  logic        instr_mode;
  logic        link_valid;
  logic [4:0]  link_idx;
  logic [31:0] link_value;
  int          n_mismatch;     // mismatches seen
  int          checks_done;    // comparisons made
  int          n_slot, n_fetch, n_link, n_clr; // pulse counts per jump
  logic [31:0] slot_pc, tgt_pc, lk;            // captured addresses
  logic [4:0]  lk_i;           // captured link index
  logic        ord;            // target fetch came after slot
  logic [31:0] stat;           // status at end of a jump
  logic        cnt_clr;        // zeroes the pulse counters before a jump

  assign hready = hreadyout;

  rjb_unit dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .hazard_set(hazard_set), .hazard_pending(hazard_pending), .hazard_clear(hazard_clear),
    .slot_valid(slot_valid), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc), .instr_mode(instr_mode),
    .link_valid(link_valid), .link_idx(link_idx), .link_value(link_value));

  // clock generator
  always #4 clk = ~clk;

  // records the pulses of each jump sequence
  always @(posedge clk)
  begin
    if (slot_valid === 1'b1) slot_pc <= fetch_pc;
    if (slot_valid === 1'b1) n_slot <= n_slot + 1;
    if (fetch_valid === 1'b1) tgt_pc <= fetch_pc;
    if (fetch_valid === 1'b1) ord <= (n_slot == 1);
    if (fetch_valid === 1'b1) n_fetch <= n_fetch + 1;
    if (hazard_clear === 1'b1) n_clr <= n_clr + 1;
    if (link_valid === 1'b1) lk <= link_value;
    if (link_valid === 1'b1) lk_i <= link_idx;
    if (link_valid === 1'b1) n_link <= n_link + 1;
    // cleared in reset and before each jump; placed last so the clear wins
    if (!rst_n || cnt_clr)
    begin
      n_slot  <= 0;
      n_fetch <= 0;
      n_link  <= 0;
      n_clr   <= 0;
    end
  end

  // verdict and end of run
  task final_report;
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer; ready and read data are taken at the rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    // address phase holds until ready is seen high at an edge
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    // data phase holds until ready is seen high again
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask

  // one-cycle hazard pulse from the core
  task automatic hz;
    hazard_set <= 1'b1;
    @(posedge clk);
    hazard_set <= 1'b0;
  endtask

  function automatic logic [31:0] jr_op(input logic [4:0] rs, input logic hb);
    return {rjb_pkg::OP_FUNC, rs, 10'h000, hb, 4'h0, rjb_pkg::FN_JR};
  endfunction

  function automatic logic [31:0] jalr_op(input logic [4:0] rs, input logic [4:0] rd, input logic hb);
    return {rjb_pkg::OP_FUNC, rs, 5'h00, rd, hb, 4'h0, rjb_pkg::FN_JALR};
  endfunction

  // loads operands, starts the jump, waits for done or refusal
  task automatic run(input logic cmp, input logic md, input logic sh, input logic [31:0] ins,
                     input logic [31:0] pc, input logic [31:0] src);
    logic [31:0] st;
    bus(1'b1, rjb_pkg::OFS_STATUS, 32'h0000_000e, st);
    bus(1'b1, rjb_pkg::OFS_CTRL, {29'h0000_0000, md, 1'b0, cmp}, st);
    bus(1'b1, rjb_pkg::OFS_INSTR, ins, st);
    bus(1'b1, rjb_pkg::OFS_PC, pc, st);
    bus(1'b1, rjb_pkg::OFS_SRC, src, st);
    cnt_clr <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
    bus(1'b1, rjb_pkg::OFS_CTRL, {29'h0000_0000, md, 1'b1, cmp}, st);
    if (sh) hz;
    do
      bus(1'b0, rjb_pkg::OFS_STATUS, 32'h0000_0000, st);
    while (st[rjb_pkg::ST_DONE] !== 1'b1 && st[rjb_pkg::ST_RESV] !== 1'b1);
    stat = st;
  endtask

  // reset values, unmapped place
  task automatic t_reset;
    logic [31:0] v;
    bus(1'b0, rjb_pkg::OFS_STATUS, 32'h0000_0000, v);
    chk(v, 32'h0000_0000);
    bus(1'b1, 8'h20, 32'hffff_ffff, v);
    bus(1'b0, 8'h20, 32'h0000_0000, v);
    chk(v, 32'h0000_0000);
    chk(hresp, 32'h0000_0000);
  endtask

  // call through register: link, slot, target
  task automatic t_call;
    run(1'b0, 1'b0, 1'b0, jalr_op(5'h05, 5'h07, 1'b0), 32'h0040_0100, 32'h0080_0200);
    chk(lk, 32'h0040_0108);
    chk(lk_i, 32'h0000_0007);
    chk(slot_pc, 32'h0040_0104);
    chk(ord, 32'h0000_0001);
    chk(tgt_pc, 32'h0080_0200);
  endtask

  // plain core: every low-bit pattern of the target
  task automatic t_plain;
    logic [31:0] v;
    for (int i = 0; i < 4; i++)
    begin
      run(1'b0, 1'b0, 1'b0, jr_op(5'h03, 1'b0), 32'h0000_1000, 32'h0000_2000 | i);
      chk(stat[rjb_pkg::ST_AERR], i != 0);
      chk(n_fetch, i == 0);
      bus(1'b0, rjb_pkg::OFS_TARGET, 32'h0000_0000, v);
      chk(v, 32'h0000_2000 | i);
    end
  endtask

  // compact core: mode from bit 0, fault only on pattern 10
  task automatic t_compact;
    logic [31:0] v;
    for (int i = 0; i < 4; i++)
    begin
      run(1'b1, 1'b0, 1'b0, jr_op(5'h04, 1'b0), 32'h0000_1000, 32'h0000_3000 | i);
      chk(stat[rjb_pkg::ST_AERR], i == 2);
      chk(n_fetch, i != 2);
      chk(instr_mode, i % 2);
      bus(1'b0, rjb_pkg::OFS_TARGET, 32'h0000_0000, v);
      chk(v, (32'h0000_3000 | i) & 32'hffff_fffe);
    end
  endtask

  // exchange call, including the region boundary
  task automatic t_exch;
    run(1'b1, 1'b0, 1'b0, {rjb_pkg::OP_EXCH, 26'h000_0040}, 32'h0fff_fffc, 32'h0000_0000);
    chk(lk, 32'h1000_0004);
    chk(lk_i, 32'h0000_001f);
    chk(tgt_pc, 32'h1000_0100);
    chk(instr_mode, 32'h0000_0001);
    run(1'b1, 1'b1, 1'b0, {rjb_pkg::OP_EXCH, 26'h3ff_ffff}, 32'h0040_0000, 32'h0000_0000);
    chk(lk, 32'h0040_0009);
    chk(tgt_pc, 32'h0fff_fffc);
    chk(slot_pc, 32'h0040_0004);
    chk(instr_mode, 32'h0000_0000);
  endtask

  // refused encodings do nothing but flag
  task automatic t_resv;
    logic [31:0] bad [4];
    bad = '{{rjb_pkg::OP_EXCH, 26'h000_0001}, jr_op(5'h02, 1'b0) | 32'h0000_0800,
            jalr_op(5'h02, 5'h1f, 1'b0) | 32'h0001_0000, 32'h0000_0000};
    for (int i = 0; i < 4; i++)
    begin
      run(1'b0, 1'b0, 1'b0, bad[i], 32'h0000_1000, 32'h0000_2000);
      chk(stat[rjb_pkg::ST_RESV], 32'h0000_0001);
      chk(n_slot + n_link + n_fetch, 32'h0000_0000);
    end
  endtask

  // barrier clears earlier hazards only, plain jump clears none
  task automatic t_haz;
    hz;
    run(1'b0, 1'b0, 1'b0, jr_op(5'h1f, 1'b0), 32'h0000_1000, 32'h0000_4000);
    chk(hazard_pending, 32'h0000_0001);
    chk(n_clr, 32'h0000_0000);
    run(1'b0, 1'b0, 1'b0, jr_op(5'h1f, 1'b1), 32'h0000_1000, 32'h0000_4000);
    chk(n_clr, 32'h0000_0001);
    chk(hazard_pending, 32'h0000_0000);
    hz;
    run(1'b0, 1'b0, 1'b1, jalr_op(5'h06, 5'h1f, 1'b1), 32'h0000_1000, 32'h0000_4000);
    chk(n_clr, 32'h0000_0001);
    chk(hazard_pending, 32'h0000_0001);
  endtask

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hazard_set = 1'b0;
    cnt_clr = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_call;
    t_plain;
    t_compact;
    t_exch;
    t_resv;
    t_haz;
    final_report;
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
